// file: mrl_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef MRL_REGS_SVH
`define MRL_REGS_SVH

// ==========================================================
// register map
`define MRL_OPT_ADDR 8'h00
`define MRL_TIMER_ADDR 8'h04
`define MRL_STATUS_ADDR 8'h08
`define MRL_CMD_ADDR 8'h0C
`define MRL_OPT_RST 32'h0000_1000
`define MRL_TIMER_RST 32'h0000_320A

// ==========================================================
// field positions
`define MRL_OPT_SW_LSB 0
`define MRL_OPT_SCDEF_BIT 8
`define MRL_OPT_JAMSEL_LSB 9
`define MRL_OPT_JAMEN_BIT 11
`define MRL_OPT_CURVE_LSB 12
`define MRL_CMD_RESET_BIT 0

// ==========================================================
// levels in percent of full load, plus thermal and temperature constants
`define MRL_FULL_LOAD_PCT 12'h064
`define MRL_JAM_BASE_PCT 12'h096
`define MRL_JAM_STEP_PCT 12'h032
`define MRL_SC_PCT 12'h3E8
`define MRL_NORM_I2 48'h0000_0005_7E40
`define MRL_CAP_PER_CURVE 32'h0000_30D4
`define MRL_COOL_STEP 24'h00_000B
`define MRL_HOT_DERATE_C 8'h64
`define MRL_HOT_DERATE_PCT 7'h32

// ==========================================================
// times and derived counts
`define MRL_CLK_NS 25
`define MRL_TICK_MS 100
`define MRL_JAM_DELAY_MS 1000
`define MRL_SC_DELAY_MS 100
`define MRL_LOCKOUT_MIN 30
`define MRL_TICK_CYCLES (`MRL_TICK_MS * 1000000 / `MRL_CLK_NS)
`define MRL_JAM_CYCLES (`MRL_JAM_DELAY_MS * 1000000 / `MRL_CLK_NS)
`define MRL_SC_CYCLES (`MRL_SC_DELAY_MS * 1000000 / `MRL_CLK_NS)
`define MRL_LOCKOUT_TICKS (`MRL_LOCKOUT_MIN * 60 * 1000 / `MRL_TICK_MS)

`endif

// file: mrl_pkg.sv
// types shared by the relay option logic
package mrl_pkg;

    // ==========================================================
    // measurement carrier
    typedef struct packed {
        logic [11:0] current_pct;
        logic starting;
        logic [7:0] temp_c;
        logic temp_fitted;
        logic emerg_restart;
        logic reset_button;
    } mrl_meas_s;

    // ==========================================================
    // trip state
    typedef enum logic [1:0] {
        MRL_RUN,
        MRL_TRIP,
        MRL_LOCK
    } mrl_trip_e;

    typedef struct packed {
        logic [3:0] curve;
        logic jam_en;
        logic [1:0] jam_sel;
        logic sc_defeat;
        logic feeder;
        logic volt_comp;
        logic temp_comp;
        logic mem_defeat;
        logic emerg_en;
        logic uc_disable;
        logic ol_warn;
        logic cyclic;
    } mrl_opt_s;

endpackage

// file: mrl_delay.sv
// qualifying delay: done once arm has held for CYCLES clocks
`timescale 1ns/1ps
module mrl_delay
    import mrl_pkg::*;
#(
    parameter int unsigned CYCLES = 4000000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic arm,
    output logic done
);
    typedef struct packed {
        logic [25:0] cnt;
        logic done;
    } mrl_dly_s;

    mrl_dly_s q;
    mrl_dly_s d;

    // ==========================================================
    // counter
    always_comb begin
        d = q;
        if (!arm) begin
            d.cnt = 26'h000_0000;
            d.done = 1'b0;
        end else if (q.cnt >= 26'(CYCLES - 1)) begin
            d.done = 1'b1;
        end else begin
            d.cnt = q.cnt + 26'h000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done = q.done;
endmodule

// file: mrl_thermal.sv
// thermal memory: heats on overload, cools otherwise, trips at capacity
`timescale 1ns/1ps
`include "mrl_regs.svh"
module mrl_thermal
    import mrl_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic [11:0] current_pct,
    input wire logic start_mode,
    input wire logic cyclic_on,
    input wire logic defeat_on,
    input wire logic discharge,
    input wire logic [6:0] derate_pct,
    input wire logic [3:0] curve,
    output logic [23:0] heat,
    output logic trip
);
    typedef struct packed {
        logic [23:0] heat;
        logic was_over;
        logic trip;
    } mrl_th_s;

    mrl_th_s q;
    mrl_th_s d;
    logic over;
    logic [31:0] cap;

    // ==========================================================
    // memory update
    always_comb begin
        d = q;
        over = current_pct > `MRL_FULL_LOAD_PCT;
        cap = 32'((curve == 4'h0) ? 4'h1 : curve) * `MRL_CAP_PER_CURVE * 32'(derate_pct);
        if (discharge) begin
            d.heat = 24'h00_0000;
        end else if (tick) begin
            d.was_over = over;
            if (over) begin
                d.heat = q.heat + 24'(current_pct - `MRL_FULL_LOAD_PCT); // [RULE_10]
            end else if (defeat_on) begin
                d.heat = 24'h00_0000; // [RULE_12]
            end else if (cyclic_on && q.was_over && !start_mode) begin
                d.heat = 24'h00_0000; // [RULE_05]
            end else if (q.heat > `MRL_COOL_STEP) begin
                d.heat = q.heat - `MRL_COOL_STEP;
            end else begin
                d.heat = 24'h00_0000;
            end
        end
        // derate shrinks capacity, so hot windings trip sooner
        d.trip = (32'(q.heat) * 32'h0000_0064) >= cap; // [RULE_13]
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign heat = q.heat;
    assign trip = q.trip;
endmodule

// file: mrl_top.sv
// motor relay option and rapid-trip logic with AXI4-Lite registers
//
// Functional notes
// [RULE_01] jam enabled: trip after surge level (150-300%) held one second
// [RULE_02] jam trip disabled during start mode
// [RULE_03] switch changes take effect immediately, no special sequence
// [RULE_04] cyclic compensation only with cyclic on and memory defeat off
// [RULE_05] cyclic: memory cleared on overload recovery; continuous overload trips
// [RULE_06] overload warning switch drives aux relay on overload
// [RULE_07] overload warning suppressed during start mode
// [RULE_08] undercurrent drives aux relay unless undercurrent disable set; code also suppresses it during start mode
// [RULE_09] emergency restart input ignored unless its enable switch is on
// [RULE_10] thermal memory accumulates overloads and starts
// [RULE_11] memory defeat allows reset at once, no thirty-minute lockout
// [RULE_12] memory defeat: earlier overloads and starts have no influence
// [RULE_13] temperature compensation derates times linearly to 50% at 100 C
// [RULE_14] temperature compensation ignored when sensing option absent
// [RULE_15] voltage compensation scales start timer by (6x / actual)^2
// [RULE_16] voltage compensation acts only while starting
// [RULE_17] feeder mode defeats start timer, run curve always active
// [RULE_18] operator should also set memory defeat in feeder mode
// [RULE_19] short circuit: trip after 100 ms above ten times full load
// [RULE_20] short circuit enabled while its defeat switch is off
// [RULE_21] jam delay restarts when current drops below surge level
// [RULE_22] main relay held tripped until a permitted reset
`timescale 1ns/1ps
`include "mrl_regs.svh"
module mrl_top
    import mrl_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `MRL_TICK_CYCLES,
    parameter int unsigned JAM_CYCLES = `MRL_JAM_CYCLES,
    parameter int unsigned SC_CYCLES = `MRL_SC_CYCLES,
    parameter int unsigned LOCKOUT_TICKS = `MRL_LOCKOUT_TICKS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input mrl_meas_s meas,
    output logic main_relay,
    output logic aux_relay
);
    // ==========================================================
    // state
    typedef struct packed {
        logic awready;
        logic aw_got;
        logic [7:0] awaddr;
        logic wready;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] opt;
        logic [31:0] timer;
        logic reset_req;
        logic [21:0] tick_cnt;
        logic tick;
        logic [15:0] start_ticks;
        logic [15:0] lock_ticks;
        mrl_trip_e trip_st;
        logic [3:0] cause;
        logic main;
        logic aux;
    } mrl_top_s;

    mrl_top_s q;
    mrl_top_s d;

    mrl_opt_s opt;
    logic start_mode;
    logic overload;
    logic undercurrent;
    logic [11:0] jam_level;
    logic jam_arm;
    logic jam_done;
    logic sc_arm;
    logic sc_done;
    logic th_trip;
    logic [23:0] heat;
    logic [6:0] derate;
    logic discharge;
    logic [47:0] i2_eff;
    logic [47:0] start_used;
    logic [47:0] start_allow;
    logic start_exp;
    logic trip_now;
    logic [3:0] trip_why;

    // ==========================================================
    // helpers
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        if (addr[7:2] == `MRL_OPT_ADDR >> 2) begin
            return 3'h1;
        end else if (addr[7:2] == `MRL_TIMER_ADDR >> 2) begin
            return 3'h2;
        end else if (addr[7:2] == `MRL_STATUS_ADDR >> 2) begin
            return 3'h3;
        end else if (addr[7:2] == `MRL_CMD_ADDR >> 2) begin
            return 3'h4;
        end else begin
            return 3'h0;
        end
    endfunction

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // option decode, read live so changes apply at once
    always_comb begin
        opt.curve = q.opt[`MRL_OPT_CURVE_LSB +: 4]; // [RULE_03]
        opt.jam_en = q.opt[`MRL_OPT_JAMEN_BIT];
        opt.jam_sel = q.opt[`MRL_OPT_JAMSEL_LSB +: 2];
        opt.sc_defeat = q.opt[`MRL_OPT_SCDEF_BIT];
        {opt.feeder, opt.volt_comp, opt.temp_comp, opt.mem_defeat,
         opt.emerg_en, opt.uc_disable, opt.ol_warn, opt.cyclic}
            = q.opt[`MRL_OPT_SW_LSB +: 8];
    end

    // ==========================================================
    // conditions
    always_comb begin
        start_mode = meas.starting && !opt.feeder; // [RULE_17]
        overload = meas.current_pct > `MRL_FULL_LOAD_PCT;
        undercurrent = (meas.current_pct != 12'h000)
            && (meas.current_pct < {4'h0, q.timer[15:8]});
        jam_level = `MRL_JAM_BASE_PCT + 12'(opt.jam_sel) * `MRL_JAM_STEP_PCT;
        // inrush is normal, so jam is held off while starting
        jam_arm = opt.jam_en && !start_mode // [RULE_02]
            && meas.current_pct > jam_level; // [RULE_01]
        sc_arm = !opt.sc_defeat // [RULE_20]
            && meas.current_pct > `MRL_SC_PCT; // [RULE_19]
        discharge = opt.emerg_en && meas.emerg_restart; // [RULE_09]
        if (opt.temp_comp && meas.temp_fitted) begin // [RULE_14]
            if (meas.temp_c >= `MRL_HOT_DERATE_C) begin
                derate = `MRL_HOT_DERATE_PCT; // [RULE_13]
            end else begin
                derate = 7'h64 - 7'(meas.temp_c >> 1);
            end
        end else begin
            derate = 7'h64;
        end
    end

    // ==========================================================
    // start timer; division avoided by cross-multiplying
    always_comb begin
        if (opt.volt_comp && start_mode) begin // [RULE_16]
            i2_eff = 48'(meas.current_pct) * 48'(meas.current_pct); // [RULE_15]
        end else begin
            i2_eff = `MRL_NORM_I2;
        end
        start_used = 48'(q.start_ticks) * i2_eff * 48'h0000_0000_0064;
        start_allow = 48'(q.timer[7:0]) * 48'h0000_0000_000A
            * `MRL_NORM_I2 * 48'(derate);
        start_exp = start_mode && (start_used >= start_allow);
    end

    // ==========================================================
    // delay qualifiers
    mrl_delay #(
        .CYCLES(JAM_CYCLES)
    ) u_jam (
        .clk(clk),
        .sys_rst(sys_rst),
        .arm(jam_arm),
        .done(jam_done)
    ); // [RULE_21]

    mrl_delay #(
        .CYCLES(SC_CYCLES)
    ) u_sc (
        .clk(clk),
        .sys_rst(sys_rst),
        .arm(sc_arm),
        .done(sc_done)
    );

    mrl_thermal u_thermal (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(q.tick),
        .current_pct(meas.current_pct),
        .start_mode(start_mode),
        .cyclic_on(opt.cyclic && !opt.mem_defeat), // [RULE_04]
        .defeat_on(opt.mem_defeat),
        .discharge(discharge),
        .derate_pct(derate),
        .curve(opt.curve),
        .heat(heat),
        .trip(th_trip)
    );

    always_comb begin
        trip_why = {start_exp, th_trip, sc_done, jam_done};
        trip_now = |trip_why;
    end

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        d.reset_req = 1'b0;

        // write channel
        if (s_axi_awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = 2'h0;
            case (reg_index(q.awaddr))
                3'h1: begin
                    d.opt = merge(q.opt, q.wdata, q.wstrb);
                    d.opt[31:16] = 16'h0000;
                end
                3'h2: begin
                    d.timer = merge(q.timer, q.wdata, q.wstrb);
                    d.timer[31:16] = 16'h0000;
                end
                3'h3: begin
                end
                3'h4: begin
                    d.reset_req = q.wstrb[0] && q.wdata[`MRL_CMD_RESET_BIT];
                end
                default: begin
                    d.bresp = 2'h2;
                end
            endcase
        end
        d.awready = !d.aw_got && !d.bvalid;
        d.wready = !d.w_got && !d.bvalid;

        // read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = 2'h0;
            case (reg_index(s_axi_araddr))
                3'h1: begin
                    d.rdata = q.opt;
                end
                3'h2: begin
                    d.rdata = q.timer;
                end
                3'h3: begin
                    d.rdata = {heat[23:8], 8'h00, q.cause, start_mode,
                        q.trip_st == MRL_LOCK, q.aux, q.main};
                end
                3'h4: begin
                    d.rdata = 32'h0000_0000;
                end
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = 2'h2;
                end
            endcase
        end
        d.arready = !d.rvalid;

        // time base
        d.tick = 1'b0;
        if (q.tick_cnt >= 22'(TICK_CYCLES - 1)) begin
            d.tick_cnt = 22'h00_0000;
            d.tick = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 22'h00_0001;
        end
        if (!start_mode) begin
            d.start_ticks = 16'h0000;
        end else if (q.tick && q.start_ticks != 16'hFFFF) begin
            d.start_ticks = q.start_ticks + 16'h0001;
        end

        // trip latch
        case (q.trip_st)
            MRL_RUN: begin
                if (trip_now) begin
                    d.cause = trip_why;
                    if (th_trip && !opt.mem_defeat) begin
                        d.trip_st = MRL_LOCK;
                        d.lock_ticks = 16'(LOCKOUT_TICKS);
                    end else begin
                        d.trip_st = MRL_TRIP;
                    end
                end
            end
            MRL_TRIP: begin
                // a reset is refused while the fault is still present
                if ((q.reset_req || meas.reset_button) && !trip_now) begin
                    d.trip_st = MRL_RUN; // [RULE_22]
                    d.cause = 4'h0;
                end
            end
            MRL_LOCK: begin
                d.cause = q.cause | trip_why;
                if (opt.mem_defeat || discharge) begin
                    d.trip_st = MRL_TRIP; // [RULE_11]
                end else if (q.lock_ticks == 16'h0000) begin
                    d.trip_st = MRL_TRIP;
                end else if (q.tick) begin
                    d.lock_ticks = q.lock_ticks - 16'h0001;
                end
            end
            default: begin
                d.trip_st = MRL_TRIP;
            end
        endcase
        d.main = d.trip_st != MRL_RUN;

        d.aux = (opt.ol_warn && overload && !start_mode) // [RULE_06] [RULE_07]
            || (!opt.uc_disable && undercurrent && !start_mode); // [RULE_08]
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
            q.opt <= `MRL_OPT_RST;
            q.timer <= `MRL_TIMER_RST;
            q.trip_st <= MRL_RUN;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign main_relay = q.main;
    assign aux_relay = q.aux;
endmodule

// file: mrl_top_properties.sv
// port checker for the relay option logic
`timescale 1ns/1ps
module mrl_props
    import mrl_pkg::*;
#(
    parameter int unsigned JAM_CYCLES = 20,
    parameter int unsigned SC_CYCLES = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire mrl_meas_s meas,
    input wire logic main_relay,
    input wire logic aux_relay
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ========================================
    // option shadow leads the design by one edge: trip bounds carry slack
    logic [15:0] opt_q;
    logic [2:0] busy_q;
    int unsigned jam_q, sc_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            opt_q <= 16'h1000;
            busy_q <= 3'h0;
            jam_q <= 0;
            sc_q <= 0;
        end else begin
            if (s_axi_wvalid && s_axi_wready && s_axi_awaddr[7:2] == 6'h00) begin
                opt_q <= s_axi_wdata[15:0];
            end
            busy_q <= (s_axi_awvalid || s_axi_bvalid) ? 3'h4 : busy_q - {2'h0, busy_q != 3'h0};
            jam_q <= (meas.current_pct > 12'h096 + 12'h032 * {10'h000, opt_q[10:9]}
                && opt_q[11] && !(meas.starting && !opt_q[7])) ? jam_q + 1 : 0;
            sc_q <= (meas.current_pct > 12'h3E8 && !opt_q[8]) ? sc_q + 1 : 0;
        end
    end
    // ========================================
    // properties
    property p_rst_idle;
        $past(sys_rst) |-> !main_relay && !aux_relay && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs active after reset");
    property p_aw_refuse;
        (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
            and (s_axi_wvalid && s_axi_wready |=> !s_axi_wready);
    endproperty
    a_aw_refuse: assert property (p_aw_refuse) else $error("write taken twice");
    property p_b_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("write response late");
    property p_ar_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_ar_answer: assert property (p_ar_answer) else $error("read response late");
    property p_relay_hold;
        main_relay && busy_q == 3'h0 && !meas.reset_button && !$past(meas.reset_button)
            && !$past(meas.reset_button, 2) |=> main_relay;
    endproperty
    a_relay_hold: assert property (p_relay_hold) else $error("trip dropped");
    property p_warn_start;
        (meas.starting && !opt_q[7]) [*3] |-> !aux_relay;
    endproperty
    a_warn_start: assert property (p_warn_start) else $error("aux in start");
    property p_jam_trip;
        jam_q == JAM_CYCLES + 4 |-> main_relay;
    endproperty
    a_jam_trip: assert property (p_jam_trip) else $error("jam trip missing");
    property p_sc_trip;
        sc_q == SC_CYCLES + 4 |-> main_relay;
    endproperty
    a_sc_trip: assert property (p_sc_trip) else $error("short trip missing");
endmodule

bind mrl_top mrl_props #(.JAM_CYCLES(JAM_CYCLES), .SC_CYCLES(SC_CYCLES)) u_props (.*);

// file: mrl_motor.sv
// motor sensing model: phase current and terminal states
`timescale 1ns/1ps
module mrl_motor
    import mrl_pkg::*;
(
    input wire logic clk,
    input wire mrl_meas_s want,
    input wire logic slow,
    output mrl_meas_s meas
);
    // ========================================
    // converter lag: one clock, three when slow
    mrl_meas_s lag_q [3] = '{default: '0};
    always @(posedge clk) begin
        lag_q[0] <= want;
        lag_q[1] <= lag_q[0];
        lag_q[2] <= lag_q[1];
    end
    assign meas = slow ? lag_q[2] : lag_q[0];
endmodule

// file: mrl_top_test.sv
// self-checking bench for the relay option logic
`timescale 1ns/1ps
module mrl_top_test
    import mrl_pkg::*;
;
    localparam int JAM = 20;
    localparam int SC = 8;
    localparam logic [31:0] AX_OPT [5] = '{32'hF012, 32'hF012, 32'hF010, 32'hF010, 32'hF014};
    localparam logic [11:0] AX_CUR [5] = '{12'h078, 12'h078, 12'h078, 12'h01E, 12'h01E};
    localparam logic [4:0] AX_ST = 5'h02;
    localparam logic [4:0] AX_EX = 5'h09;
    logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic main_relay, aux_relay, slow;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [11:0] lv;
    mrl_meas_s want, meas;
    int n_mismatch, check_count, cyc;
    mrl_top #(.TICK_CYCLES(10), .JAM_CYCLES(JAM), .SC_CYCLES(SC), .LOCKOUT_TICKS(5)) u_dut (
        .*, .s_axi_wstrb(4'hF));
    mrl_motor u_motor (.clk(clk), .want(want), .slow(slow), .meas(meas));
    // ========================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic opt(input logic [31:0] d);
        wr(8'h00, d, rs);
    endtask
    task automatic amps(input logic [11:0] c, input int n);
        want.current_pct <= c;
        repeat (n) @(posedge clk);
    endtask
    // held so the slow converter still sees it
    task automatic press;
        want.reset_button <= 1'b1;
        repeat (4) @(posedge clk);
        want.reset_button <= 1'b0;
    endtask
    task automatic wait_main(input logic exp, input int lim);
        for (int i = 0; i < lim && main_relay !== exp; i++) @(posedge clk);
        chk(main_relay, exp);
    endtask
    task automatic clr;
        amps(12'h000, 8);
        chk(main_relay, 1'b1);
        press();
        wait_main(1'b0, 15);
    endtask
    // ========================================
    // clock, timeout, sequence
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow}
            = 7'h40;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        want = '0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h00, rv, rs);
        chk(rv, 32'h0000_1000);
        rd(8'h04, rv, rs);
        chk(rv, 32'h0000_320A);
        rd(8'h10, rv, rs);
        chk({rv[29:0], rs}, 32'h2);
        wr(8'h14, 32'h1, rs);
        chk(rs, 2'h2);
        // jam at each level; a dip restarts the delay
        for (int s = 0; s < 4; s++) begin
            lv = 12'h096 + 12'h032 * s[11:0];
            opt(32'h0000_F810 | {s[1:0], 9'h000});
            amps(lv + 12'h001, JAM - 5);
            amps(lv, 3);
            amps(lv + 12'h001, JAM - 5);
            chk(main_relay, 1'b0);
            repeat (12) @(posedge clk);
            chk(main_relay, 1'b1);
            clr();
        end
        // start mode blocks jam and warning
        opt(32'h0000_F812);
        want.starting <= 1'b1;
        amps(12'h12C, JAM + 10);
        chk(main_relay, 1'b0);
        chk(aux_relay, 1'b0);
        opt(32'h0000_F892);
        wait_main(1'b1, JAM + 10);
        chk(aux_relay, 1'b1);
        want.starting <= 1'b0;
        clr();
        // short circuit defeated, then enabled
        opt(32'h0000_F112);
        amps(12'h3E9, SC + 10);
        chk(main_relay, 1'b0);
        opt(32'h0000_F012);
        amps(12'h3E9, SC + 8);
        chk(main_relay, 1'b1);
        clr();
        // auxiliary relay sources
        for (int i = 0; i < 5; i++) begin
            opt(AX_OPT[i]);
            want.starting <= AX_ST[i];
            amps(AX_CUR[i], 6);
            chk(aux_relay, AX_EX[i]);
        end
        // thermal lockout with a slow converter
        amps(12'h000, 40);
        opt(32'h0000_1000);
        slow <= 1'b1;
        amps(12'h384, 0);
        wait_main(1'b1, 400);
        want.emerg_restart <= 1'b1;
        amps(12'h000, 35);
        press();
        amps(12'h000, 6);
        chk(main_relay, 1'b1);
        want.emerg_restart <= 1'b0;
        opt(32'h0000_1010);
        amps(12'h000, 20);
        press();
        wait_main(1'b0, 40);
        end_sim();
    end
endmodule
